// [src/lcdsp_pkg.sv]
/*
  Constants for the serial command port of the segment LCD driver:
  slave address, command layout, drive modes, reset values and the
  phase codes of the receiver. Assumes nothing of its surroundings.
*/
package lcdsp_pkg;

  // Upper six bits of the 7-bit slave address; bit 0 comes from a pin.
  localparam logic [5:0] SLAVE_ADDR_HI  = 6'h1c;

  // Bit counter values within one byte plus its acknowledge clock.
  localparam logic [3:0] BIT_CNT_RST    = 4'h0;
  localparam logic [3:0] BIT_BYTE_DONE  = 4'h8;
  localparam logic [3:0] BIT_ACK_DONE   = 4'h9;

  // Command byte field positions.
  localparam int CMD_CONT_BIT   = 7;
  localparam int CMD_GROUP_BIT  = 6;
  localparam int CMD_SUB_BIT    = 5;
  localparam int MS_ENABLE_BIT  = 3;
  localparam int MS_BIAS_BIT    = 2;
  localparam int BS_IN_BIT      = 1;
  localparam int BS_OUT_BIT     = 0;
  localparam int BL_ALT_BIT     = 2;

  // Second level selector in bits 4:3 of the 11x command group.
  localparam logic [1:0] SEL_DEVICE     = 2'h0;
  localparam logic [1:0] SEL_BLINK      = 2'h2;
  localparam logic [1:0] SEL_BANK       = 2'h3;

  // Drive mode encodings.
  localparam logic [1:0] MODE_STATIC    = 2'h1;
  localparam logic [1:0] MODE_MUX2      = 2'h2;
  localparam logic [1:0] MODE_MUX3      = 2'h3;
  localparam logic [1:0] MODE_MUX4      = 2'h0;

  // Data pointer advance per stored byte, and its range.
  localparam logic [6:0] PTR_INC_STATIC = 7'h08;
  localparam logic [6:0] PTR_INC_MUX2   = 7'h04;
  localparam logic [6:0] PTR_INC_MUX3   = 7'h03;
  localparam logic [6:0] PTR_INC_MUX4   = 7'h02;
  localparam logic [6:0] PTR_SPAN       = 7'h28;

  // Values after reset.
  localparam logic [1:0] RST_MODE       = 2'h1;
  localparam logic [5:0] RST_PTR        = 6'h00;
  localparam logic [2:0] RST_SUBADDR    = 3'h0;
  localparam logic [1:0] RST_BLINK      = 2'h0;
  localparam logic [7:0] RST_BYTE       = 8'h00;

  // Synchroniser width: scl, sda, address pin, three subaddress pins.
  localparam int SYNC_W = 6;

  // Receiver phase, one-hot.
  typedef enum logic [3:0] {
    PH_ADDR   = 4'b0001,
    PH_CMD    = 4'b0010,
    PH_DATA   = 4'b0100,
    PH_IGNORE = 4'b1000
  } lcdsp_phase_t;

endpackage

// [src/lcdsp_sync.sv]
/*
  Two flip-flop synchroniser for a group of independent levels.
  Assumes each bit is a level that stays put for several clocks.
*/
`timescale 1ns/1ps
`default_nettype none
module lcdsp_sync #(
  parameter int W = 1
) (
  input  wire logic         clock,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] d,
  output var  logic [W-1:0] q
);

  logic [W-1:0] meta_r;

  // Each bit has its own pair; the first stage feeds only the second.
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      always_ff @(posedge clock) begin
        if (!rst_n) begin
          meta_r[i] <= 1'b1;
          q[i]      <= 1'b1;
        end else begin
          meta_r[i] <= d[i];
          q[i]      <= meta_r[i];
        end
      end
    end
  endgenerate

endmodule
`default_nettype wire

// [src/lcdsp_port.sv]
/*
  Write-only two-wire serial slave receiver and command decoder for a
  segment LCD driver. Bits are shifted on the serial clock; framing,
  decoding and the acknowledge run on the 40 MHz system clock.
  Assumes the data line is wired from sda_in, sda_out and sda_oe_n
  with a pull-up, and that the strap pins are static during access.
*/
// Summary of operation
// - One bit per serial clock; data stable while clock high.
// - Data falling while clock high is a start.
// - Data rising while clock high is a stop.
// - Eight-bit bytes, each followed by an acknowledge clock, unlimited.
// - Acknowledge holds data low through the ninth clock's high phase.
// - Slave receiver only; drives nothing but the acknowledge.
// - Answers address 0111 00x, x equal to the address pin.
// - Read requests get no acknowledge and no response.
// - All devices with matching address pin acknowledge together.
// - A non-matching device ignores the whole transfer.
// - Addressed devices acknowledge every command byte.
// - Command bit 7 set means more commands; clear starts data.
// - Data bytes go out with pointer and subaddress, both advancing.
// - Data bytes acknowledged only when subaddress pins match counter.
// - Command decode: pointer, mode-set, device, bank, blink select.
// - Mode-set bit 3 enables or blanks the display.
// - Bias bit and drive-mode field come from mode-set.
// - Pointer load puts six-bit value into data pointer.
// - Device-select loads three-bit subaddress counter.
// - Bank-select sets input and output bank; static, two-way only.
// - Blink-select sets rate and alternate bank, forced normal above 1:2.
`timescale 1ns/1ps
`default_nettype none
module lcdsp_port (
  input  wire logic       clock,
  input  wire logic       rst_n,
  input  wire logic       scl_clk,
  input  wire logic       sda_in,
  output var  logic       sda_out,
  output var  logic       sda_oe_n,
  input  wire logic       slave_addr_lsb_pin,
  input  wire logic       hw_subaddr_pin_0,
  input  wire logic       hw_subaddr_pin_1,
  input  wire logic       hw_subaddr_pin_2,
  output var  logic       display_en,
  output var  logic       bias_half,
  output var  logic [1:0] drive_mode,
  output var  logic       in_bank,
  output var  logic       out_bank,
  output var  logic [1:0] blink_rate_field,
  output var  logic       blink_alt,
  output var  logic [5:0] data_ptr,
  output var  logic [2:0] subaddr_cnt,
  output var  logic       ram_wr_stb,
  output var  logic [7:0] ram_wr_data,
  output var  logic [5:0] ram_wr_ptr,
  output var  logic       addressed
);

  // Every check below belongs to the system clock domain.
  default clocking cb_sys @(posedge clock); endclocking
  default disable iff (!rst_n);

  // Link domain: shift register and one toggle per serial clock rise.
  // Reset here is asynchronous because the serial clock may not run.
  logic [7:0] link_sh_r;
  logic       link_tog_r;

  always_ff @(posedge scl_clk or negedge rst_n) begin
    if (!rst_n) begin
      link_sh_r  <= lcdsp_pkg::RST_BYTE;
      link_tog_r <= 1'b0;
    end else begin
      link_sh_r  <= {link_sh_r[6:0], sda_in};
      link_tog_r <= ~link_tog_r;
    end
  end

  // Pins and the edge toggle enter the system domain through two flops.
  logic [lcdsp_pkg::SYNC_W-1:0] pins_s;
  logic [1:0]                   tog_s;

  lcdsp_sync #(.W(lcdsp_pkg::SYNC_W)) u_pin_sync (
    .clock (clock),
    .rst_n (rst_n),
    .d     ({hw_subaddr_pin_2, hw_subaddr_pin_1, hw_subaddr_pin_0,
             slave_addr_lsb_pin, sda_in, scl_clk}),
    .q     (pins_s)
  );

  lcdsp_sync #(.W(2)) u_tog_sync (
    .clock (clock),
    .rst_n (rst_n),
    .d     ({1'b1, ~link_tog_r}),
    .q     (tog_s)
  );

  wire       scl_s  = pins_s[0];
  wire       sda_s  = pins_s[1];
  wire       sa0_s  = pins_s[2];
  wire [2:0] hwsa_s = pins_s[5:3];

  // Delayed copies for edge detection, taken after the synchronisers.
  logic scl_d_r;
  logic sda_d_r;
  logic tog_d_r;

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
      tog_d_r <= 1'b1; // Matches the inverted toggle's idle level.
    end else begin
      scl_d_r <= scl_s;
      sda_d_r <= sda_s;
      tog_d_r <= tog_s[0];
    end
  end

  // Bus conditions. Sampling both lines together keeps a data change
  // near the clock edge from looking like a start or stop.
  wire start_det = scl_s & scl_d_r & sda_d_r & ~sda_s;
  wire stop_det  = scl_s & scl_d_r & ~sda_d_r & sda_s;
  wire frame_clr = start_det | stop_det;
  wire scl_rise  = tog_s[0] ^ tog_d_r;
  wire scl_fall  = scl_d_r & ~scl_s;

  // Receiver state.
  lcdsp_pkg::lcdsp_phase_t phase_r;
  lcdsp_pkg::lcdsp_phase_t phase_nxt;
  logic [3:0] bit_cnt_r;
  logic [3:0] bit_cnt_nxt;
  logic       ack_pend_r;
  logic       ack_pend_nxt;
  logic       sda_oe_n_nxt;

  // The byte is stable in the link register for a whole bit time after
  // the toggle, so the eighth rise may read it directly.
  wire [3:0] bit_cnt_inc = bit_cnt_r + 4'h1;
  wire       cap         = scl_rise
                         & (bit_cnt_inc == lcdsp_pkg::BIT_BYTE_DONE);
  wire [7:0] rx_byte     = link_sh_r;

  // Address and command decode.
  wire addr_hit  = (rx_byte[7:1]
                 == {lcdsp_pkg::SLAVE_ADDR_HI, sa0_s});
  wire addr_wr   = ~rx_byte[0];
  wire cmd_cont  = rx_byte[lcdsp_pkg::CMD_CONT_BIT];
  wire is_ptr    = ~rx_byte[lcdsp_pkg::CMD_GROUP_BIT];
  wire is_mode   = rx_byte[lcdsp_pkg::CMD_GROUP_BIT]
                 & ~rx_byte[lcdsp_pkg::CMD_SUB_BIT];
  wire is_ext    = rx_byte[lcdsp_pkg::CMD_GROUP_BIT]
                 & rx_byte[lcdsp_pkg::CMD_SUB_BIT];
  wire is_dev    = is_ext & (rx_byte[4:3] == lcdsp_pkg::SEL_DEVICE);
  wire is_bank   = is_ext & (rx_byte[4:3] == lcdsp_pkg::SEL_BANK);
  wire is_blink  = is_ext & (rx_byte[4:3] == lcdsp_pkg::SEL_BLINK);
  wire sub_match = (hwsa_s == subaddr_cnt);

  wire in_addr   = (phase_r == lcdsp_pkg::PH_ADDR);
  wire in_cmd    = (phase_r == lcdsp_pkg::PH_CMD);
  wire in_data   = (phase_r == lcdsp_pkg::PH_DATA);
  wire cap_cmd   = cap & in_cmd;
  wire cap_data  = cap & in_data;

  // Bank switching only exists in static and two-way multiplex.
  wire bank_ok   = (drive_mode == lcdsp_pkg::MODE_STATIC)
                 | (drive_mode == lcdsp_pkg::MODE_MUX2);

  // Phase and bit counting. Start and stop take priority over all else.
  always_comb begin
    phase_nxt    = phase_r;
    bit_cnt_nxt  = bit_cnt_r;
    ack_pend_nxt = ack_pend_r;
    sda_oe_n_nxt = sda_oe_n;
    if (frame_clr) begin
      phase_nxt    = lcdsp_pkg::PH_ADDR;
      bit_cnt_nxt  = lcdsp_pkg::BIT_CNT_RST;
      ack_pend_nxt = 1'b0;
      sda_oe_n_nxt = 1'b1;
    end else begin
      if (scl_rise) begin
        bit_cnt_nxt = bit_cnt_inc;
      end
      if (cap) begin
        unique case (phase_r)
          lcdsp_pkg::PH_ADDR: begin
            if (addr_hit && addr_wr) begin
              phase_nxt    = lcdsp_pkg::PH_CMD;
              ack_pend_nxt = 1'b1;
            end else begin
              phase_nxt    = lcdsp_pkg::PH_IGNORE;
              ack_pend_nxt = 1'b0;
            end
          end
          lcdsp_pkg::PH_CMD: begin
            ack_pend_nxt = 1'b1;
            if (!cmd_cont) begin
              phase_nxt = lcdsp_pkg::PH_DATA;
            end
          end
          lcdsp_pkg::PH_DATA: begin
            ack_pend_nxt = sub_match;
          end
          lcdsp_pkg::PH_IGNORE: begin
            ack_pend_nxt = 1'b0;
          end
          default: begin
            phase_nxt    = lcdsp_pkg::PH_IGNORE;
            ack_pend_nxt = 1'b0;
          end
        endcase
      end
      // Drive low from the fall after bit eight to the fall after nine.
      if (scl_fall && bit_cnt_r == lcdsp_pkg::BIT_BYTE_DONE) begin
        sda_oe_n_nxt = ~ack_pend_r;
      end
      if (scl_fall && bit_cnt_r == lcdsp_pkg::BIT_ACK_DONE) begin
        sda_oe_n_nxt = 1'b1;
        ack_pend_nxt = 1'b0;
        bit_cnt_nxt  = lcdsp_pkg::BIT_CNT_RST;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      phase_r    <= lcdsp_pkg::PH_IGNORE;
      bit_cnt_r  <= lcdsp_pkg::BIT_CNT_RST;
      ack_pend_r <= 1'b0;
      sda_oe_n   <= 1'b1;
      sda_out    <= 1'b0;
      addressed  <= 1'b0;
    end else begin
      phase_r    <= phase_nxt;
      bit_cnt_r  <= bit_cnt_nxt;
      ack_pend_r <= ack_pend_nxt;
      sda_oe_n   <= sda_oe_n_nxt;
      sda_out    <= 1'b0;
      addressed  <= (phase_nxt == lcdsp_pkg::PH_CMD)
                  | (phase_nxt == lcdsp_pkg::PH_DATA);
    end
  end

  // Pointer advance per stored byte; past the last address the pointer
  // wraps with its remainder and the subaddress counter moves on, so a
  // cascade keeps filling across the device boundary.
  logic [6:0] ptr_inc;
  always_comb begin
    unique case (drive_mode)
      lcdsp_pkg::MODE_STATIC: ptr_inc = lcdsp_pkg::PTR_INC_STATIC;
      lcdsp_pkg::MODE_MUX2:   ptr_inc = lcdsp_pkg::PTR_INC_MUX2;
      lcdsp_pkg::MODE_MUX3:   ptr_inc = lcdsp_pkg::PTR_INC_MUX3;
      lcdsp_pkg::MODE_MUX4:   ptr_inc = lcdsp_pkg::PTR_INC_MUX4;
    endcase
  end

  wire [6:0] ptr_sum  = {1'b0, data_ptr} + ptr_inc;
  wire       ptr_ovf  = (ptr_sum >= lcdsp_pkg::PTR_SPAN);
  wire [6:0] ptr_wrap = ptr_sum - lcdsp_pkg::PTR_SPAN;
  wire [5:0] ptr_adv  = ptr_ovf ? ptr_wrap[5:0] : ptr_sum[5:0];

  // Command execution, one byte at a time.
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      display_en       <= 1'b0;
      bias_half        <= 1'b0;
      drive_mode       <= lcdsp_pkg::RST_MODE;
      data_ptr         <= lcdsp_pkg::RST_PTR;
      subaddr_cnt      <= lcdsp_pkg::RST_SUBADDR;
      in_bank          <= 1'b0;
      out_bank         <= 1'b0;
      blink_rate_field <= lcdsp_pkg::RST_BLINK;
      blink_alt        <= 1'b0;
    end else if (cap_cmd) begin
      if (is_mode) begin
        display_en <= rx_byte[lcdsp_pkg::MS_ENABLE_BIT];
        bias_half  <= rx_byte[lcdsp_pkg::MS_BIAS_BIT];
        drive_mode <= rx_byte[1:0];
      end
      if (is_ptr) begin
        data_ptr <= rx_byte[5:0];
      end
      if (is_dev) begin
        subaddr_cnt <= rx_byte[2:0];
      end
      if (is_bank && bank_ok) begin
        in_bank  <= rx_byte[lcdsp_pkg::BS_IN_BIT];
        out_bank <= rx_byte[lcdsp_pkg::BS_OUT_BIT];
      end
      if (is_blink) begin
        blink_rate_field <= rx_byte[1:0];
        blink_alt        <= rx_byte[lcdsp_pkg::BL_ALT_BIT] & bank_ok;
      end
    end else if (cap_data) begin
      data_ptr <= ptr_adv;
      if (ptr_ovf) begin
        subaddr_cnt <= subaddr_cnt + 3'h1;
      end
    end
  end

  // Data goes out as it arrives, without waiting for the acknowledge.
  // Storage is inhibited on a subaddress mismatch, yet the pointer moves.
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      ram_wr_stb  <= 1'b0;
      ram_wr_data <= lcdsp_pkg::RST_BYTE;
      ram_wr_ptr  <= lcdsp_pkg::RST_PTR;
    end else begin
      ram_wr_stb <= cap_data & sub_match;
      if (cap_data) begin
        ram_wr_data <= rx_byte;
        ram_wr_ptr  <= data_ptr;
      end
    end
  end

  // Checks on the receiver.
  a_start_to_addr: assert property (
    start_det |=> in_addr && bit_cnt_r == 4'h0 && sda_oe_n)
    else $error("start did not return receiver to address phase");

  a_stop_to_addr: assert property (
    stop_det |=> in_addr && !ack_pend_r)
    else $error("stop did not clear the receiver");

  a_read_ignored: assert property (
    cap && in_addr && !addr_wr && !frame_clr
    |=> phase_r == lcdsp_pkg::PH_IGNORE && !ack_pend_r)
    else $error("read address was not ignored");

  a_addr_mismatch: assert property (
    cap && in_addr && !addr_hit && !frame_clr
    |=> phase_r == lcdsp_pkg::PH_IGNORE)
    else $error("foreign address was not ignored");

  a_addr_ack: assert property (
    cap && in_addr && addr_hit && addr_wr && !frame_clr
    |=> in_cmd && ack_pend_r)
    else $error("own write address not acknowledged");

  a_ignore_quiet: assert property (
    phase_r == lcdsp_pkg::PH_IGNORE && sda_oe_n |=> sda_oe_n)
    else $error("data line driven while not addressed");

  a_drive_only_low: assert property (
    $fell(sda_oe_n) |-> !sda_out && $past(bit_cnt_r) == 4'h8)
    else $error("data line driven outside acknowledge slot");

  a_cmd_ack: assert property (
    cap_cmd && !frame_clr |=> ack_pend_r)
    else $error("command byte not acknowledged");

  a_last_cmd: assert property (
    cap_cmd && !cmd_cont && !frame_clr |=> in_data)
    else $error("cleared continuation bit did not start data");

  a_ptr_load: assert property (
    cap_cmd && is_ptr |=> data_ptr == $past(rx_byte[5:0]))
    else $error("pointer load did not take the value");

  a_data_sub: assert property (
    cap_data && !sub_match && !frame_clr |=> !ack_pend_r ##0 !ram_wr_stb)
    else $error("data acknowledged with wrong subaddress");

  a_mode_set: assert property (
    cap_cmd && is_mode |=> display_en == $past(rx_byte[3])
      && drive_mode == $past(rx_byte[1:0]))
    else $error("mode-set fields not taken");

endmodule
`default_nettype wire

// [testbench/lcdsp_master.sv]
/*
  Behavioural two-wire bus master for the serial command port bench.
  Assumes the bench resolves the data line from sda_drv and the device
  enable with a pull-up, and feeds the resolved level back on sda.
*/
`timescale 1ns/1ps
`default_nettype none
module lcdsp_master (
  output var  logic scl,
  output var  logic sda_drv,
  input  wire logic sda
);
  // Both lines rest high; the clock stands still between frames.
  initial begin
    scl     = 1'b1;
    sda_drv = 1'b1;
  end

  // Start or repeated start; from a low clock the data is released first.
  task automatic start();
    #62 sda_drv = 1'b1;
    #63 scl = 1'b1;
    #125 sda_drv = 1'b0;
    #125 scl = 1'b0;
  endtask

  // Stop leaves both lines high, so the bus is idle afterwards.
  task automatic stop();
    #62 sda_drv = 1'b0;
    #63 scl = 1'b1;
    #125 sda_drv = 1'b1;
    #125;
  endtask

  // Data changes only mid-way through the low phase, which keeps it
  // clear of both clock edges; the ninth clock reads the acknowledge.
  task automatic send_byte(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      #62 sda_drv = b[i];
      #63 scl = 1'b1;
      #125 scl = 1'b0;
    end
    #62 sda_drv = 1'b1;
    #63 scl = 1'b1;
    #62 ack = (sda === 1'b0);
    #63 scl = 1'b0;
  endtask
endmodule
`default_nettype wire

// [testbench/lcdsp_port_tb.sv]
/*
  Self-checking bench for the serial command port: random commands and
  display bytes with corner cases, checked against a model kept here.
  Assumes the master model drives the serial lines on its own timebase.
*/
`timescale 1ns/1ps
`default_nettype none
module lcdsp_port_tb;
  logic       clock = 1'b0;
  logic       rst_n, sa_pin, scl, sda_drv, sda_line, sda_out, sda_oe_n;
  logic       display_en, bias_half, in_bank, out_bank, blink_alt;
  logic       ram_wr_stb, addressed;
  logic       e_en, e_bias, e_in, e_out, e_alt;
  logic [1:0] drive_mode, blink_rate_field, e_mode, e_rate;
  logic [2:0] sub_pins, subaddr_cnt, e_sub;
  logic [5:0] data_ptr, ram_wr_ptr, e_ptr;
  logic [7:0] ram_wr_data;
  logic [31:0] rs = 32'h21;
  int         errors = 0;
  int         n_compared = 0;
  int         stb_cnt = 0;

  // The device can only pull low; the pull-up supplies every high level.
  assign sda_line = sda_drv & (sda_oe_n | sda_out);

  always #12.5 clock = ~clock;

  // Strobes are counted so that a missing or doubled store shows up.
  always @(posedge clock) begin
    if (ram_wr_stb === 1'b1) stb_cnt <= stb_cnt + 1;
  end

  lcdsp_port u_lcdsp_port (
    .clock(clock), .rst_n(rst_n), .scl_clk(scl), .sda_in(sda_line),
    .sda_out(sda_out), .sda_oe_n(sda_oe_n),
    .slave_addr_lsb_pin(sa_pin), .hw_subaddr_pin_0(sub_pins[0]),
    .hw_subaddr_pin_1(sub_pins[1]), .hw_subaddr_pin_2(sub_pins[2]),
    .display_en(display_en), .bias_half(bias_half),
    .drive_mode(drive_mode), .in_bank(in_bank), .out_bank(out_bank),
    .blink_rate_field(blink_rate_field), .blink_alt(blink_alt),
    .data_ptr(data_ptr), .subaddr_cnt(subaddr_cnt),
    .ram_wr_stb(ram_wr_stb), .ram_wr_data(ram_wr_data),
    .ram_wr_ptr(ram_wr_ptr), .addressed(addressed)
  );

  lcdsp_master u_lcdsp_master (
    .scl(scl), .sda_drv(sda_drv), .sda(sda_line)
  );

  // Xorshift generator; a fixed seed keeps every run identical.
  function automatic logic [7:0] rnd();
    rs ^= rs << 13;
    rs ^= rs >> 17;
    rs ^= rs << 5;
    return rs[7:0];
  endfunction

  // Pointer step per stored byte for each drive mode.
  function automatic logic [6:0] step(input logic [1:0] m);
    return (m == 2'h1) ? 7'h08 : (m == 2'h2) ? 7'h04 :
           (m == 2'h3) ? 7'h03 : 7'h02;
  endfunction

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One command byte: update the model, send it, compare the outputs.
  task automatic cmd(input logic [7:0] b);
    logic ack;
    logic two;
    two = (e_mode == 2'h1) || (e_mode == 2'h2);
    if (!b[6]) e_ptr = b[5:0];
    else if (!b[5]) {e_en, e_bias, e_mode} = b[3:0];
    else if (b[4:3] == 2'h0) e_sub = b[2:0];
    else if (b[4:3] == 2'h3 && two) {e_in, e_out} = b[1:0];
    else if (b[4:3] == 2'h2) begin
      e_rate = b[1:0];
      e_alt  = b[2] & two;
    end
    u_lcdsp_master.send_byte(b, ack);
    chk(ack, 1'b1);
    chk(display_en, e_en);
    chk({bias_half, drive_mode}, {e_bias, e_mode});
    chk({in_bank, out_bank}, {e_in, e_out});
    chk(blink_rate_field, e_rate);
    if (b[6:3] == 4'he) chk(blink_alt, e_alt);
    chk(subaddr_cnt, e_sub);
    chk(data_ptr, e_ptr);
  endtask

  // One display byte: stored and acknowledged only on a subaddress match.
  task automatic data(input logic [7:0] b);
    logic ack;
    logic hit;
    int n0;
    logic [6:0] nx;
    hit = (e_sub === sub_pins);
    n0 = stb_cnt;
    u_lcdsp_master.send_byte(b, ack);
    chk(ack, hit);
    chk(8'(stb_cnt - n0), {7'h0, hit});
    if (hit) chk(ram_wr_data, b);
    if (hit) chk(ram_wr_ptr, e_ptr);
    nx = {1'b0, e_ptr} + step(e_mode);
    if (nx >= 7'h28) begin
      nx = nx - 7'h28;
      e_sub = e_sub + 3'h1;
    end
    e_ptr = nx[5:0];
    chk(data_ptr, e_ptr);
    chk(subaddr_cnt, e_sub);
  endtask

  task automatic conclude();
    $display("compared %0d, errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // Whole run is under 100 us; four times that means a hang.
  initial begin
    #400000;
    errors++;
    conclude();
  end

  initial begin
    logic ack;
    logic [7:0] r;
    logic [7:0] bad [3];
    rst_n = 1'b0;
    sa_pin = 1'b0;
    sub_pins = 3'h0;
    {e_en, e_bias, e_mode, e_in, e_out, e_rate, e_alt} = 9'h040;
    e_ptr = 6'h00;
    e_sub = 3'h0;
    repeat (2) @(posedge clock);
    #2;
    rst_n = 1'b1;
    r = rnd();
    sa_pin = r[0];
    sub_pins = r[3:1];
    repeat (3) @(posedge clock);
    chk({display_en, drive_mode, sda_oe_n, addressed}, 8'h06);
    // Every drive mode once; pointer 39 forces a wrap, and the last
    // pass selects a foreign subaddress; even passes end in a restart.
    for (int k = 0; k < 4; k++) begin
      u_lcdsp_master.start();
      u_lcdsp_master.send_byte({6'h1c, sa_pin, 1'b0}, ack);
      chk(ack, 1'b1);
      chk(addressed, 1'b1);
      r = rnd();
      cmd({3'h6, r[2:0], 2'(k)});
      cmd({5'h1e, r[3], 2'(k)});
      cmd({6'h3e, r[5:4]});
      cmd({5'h1c, (k == 3) ? sub_pins ^ 3'h1 : sub_pins});
      r = rnd();
      cmd({2'h0, (k == 0) ? 6'h27 : 6'(r % 40)});
      for (int j = 0; j < 3; j++) data(rnd());
      if (k[0]) begin
        u_lcdsp_master.stop();
        repeat (10) @(posedge clock);
        chk(addressed, 1'b0);
      end
    end
    // Foreign address pin, read request and foreign upper bits.
    bad[0] = {6'h1c, ~sa_pin, 1'b0};
    bad[1] = {6'h1c, sa_pin, 1'b1};
    bad[2] = {6'h1d, sa_pin, 1'b0};
    foreach (bad[i]) begin
      u_lcdsp_master.start();
      u_lcdsp_master.send_byte(bad[i], ack);
      chk(ack, 1'b0);
      u_lcdsp_master.send_byte(8'h48, ack);
      chk(ack, 1'b0);
      chk({display_en, drive_mode}, {e_en, e_mode});
      u_lcdsp_master.stop();
    end
    conclude();
  end
endmodule
`default_nettype wire
